// [logic/ortt_core.sv]
// Orientation trip threshold register, angle decode and portrait/landscape tracker.
`timescale 1ns/100ps

// Function
// RULE_01 - Register 2Ch is read/write, threshold code in bits 7:3, hysteresis code in bits 2:0.
// RULE_02 - The threshold code resets to 10h, a trip angle of 45 degrees.
// RULE_03 - The threshold code selects one of 32 rising angles from 0.0 to 88.2 degrees.
// RULE_04 - Landscape to portrait trips at threshold plus hysteresis, back at threshold minus it.
// RULE_05 - Up and down mean Y near -1 g and +1 g, right and left mean X near +1 g and -1 g.
// RULE_06 - Each sample is judged by axis magnitudes against tangent ratios, not arctangents.
module ortt_core
    import ortt_pkg::*;
(
    input  wire logic         core_clk_i,
    input  wire logic         rst_b_i,
    input  wire logic [7:0]   reg_addr_i,
    input  wire logic         reg_wr_i,
    input  wire logic [7:0]   reg_wdata_i,
    input  wire logic         reg_rd_i,
    output logic      [7:0]   reg_rdata_o,
    input  wire logic         sample_valid_i,
    input  wire ortt_sample_s sample_i,
    output ortt_orient_e      orient_o,
    output logic              orient_valid_o,
    output logic              orient_change_o,
    output ortt_trip_s        trip_o
);

    ////////////////////////////////////////////////////////////////////////////////
    localparam int PROD_W = ORTT_ACC_W + ORTT_TAN_W;

    function automatic logic [ORTT_ACC_W-1:0] mag(input logic signed [ORTT_ACC_W-1:0] v);
        logic [ORTT_ACC_W-1:0] r;
        r = v[ORTT_ACC_W-1] ? ORTT_ACC_W'(-v) : ORTT_ACC_W'(v);
        return r;
    endfunction

    function automatic logic is_portrait(input ortt_orient_e o);
        logic r;
        r = (o == ORTT_PORTRAIT_UP) || (o == ORTT_PORTRAIT_DOWN);
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0] trip_cfg;

    wire logic                  cfg_hit;
    wire logic [4:0]            ths_code;
    wire logic [2:0]            hys_code;
    wire logic [9:0]            ths_tenths;
    wire logic [9:0]            ths_round;
    wire logic [ORTT_ANG_W-1:0] ths_deg;
    wire logic [ORTT_ANG_W-1:0] hys_deg;
    wire logic [ORTT_ANG_W:0]   l2p_sum;
    wire logic [ORTT_ANG_W-1:0] l2p_deg;
    wire logic [ORTT_ANG_W-1:0] p2l_deg;
    wire logic [7:0]            next_rdata;

    assign cfg_hit = (reg_addr_i == ORTT_CFG_ADDR);

    // RULE_01 register write
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            // RULE_02 default 45 degrees
            trip_cfg <= ORTT_CFG_RESET;
        end else if (reg_wr_i && cfg_hit) begin
            trip_cfg <= reg_wdata_i;
        end
    end

    // RULE_01 field split
    assign ths_code = trip_cfg[ORTT_THS_MSB:ORTT_THS_LSB];
    assign hys_code = trip_cfg[ORTT_HYS_MSB:ORTT_HYS_LSB];

    // RULE_01 registered readback
    assign next_rdata = cfg_hit ? trip_cfg : 8'h00;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // RULE_03 angle table decode
    assign ths_tenths = ORTT_THS_TENTHS[ths_code];
    // Whole degrees are enough: the tangent table is coarser than the table's tenths anyway.
    assign ths_round  = (ths_tenths + 10'h005) / 10'h00A;
    assign ths_deg    = ths_round[ORTT_ANG_W-1:0];
    assign hys_deg    = ORTT_HYS_DEG[hys_code];

    // RULE_04 symmetric hysteresis
    assign l2p_sum = {1'b0, ths_deg} + {1'b0, hys_deg};
    assign l2p_deg = (l2p_sum > {1'b0, ORTT_ANGLE_MAX}) ? ORTT_ANGLE_MAX
                                                         : l2p_sum[ORTT_ANG_W-1:0];
    assign p2l_deg = (ths_deg > hys_deg) ? (ths_deg - hys_deg) : 7'h00;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            trip_o <= '0;
        end else begin
            trip_o <= '{l2p_deg: l2p_deg, p2l_deg: p2l_deg};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    wire logic [ORTT_TAN_W-1:0] tan_l2p;
    wire logic [ORTT_TAN_W-1:0] tan_p2l;

    ortt_tan_rom u_tan_rom (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .addr_a_i   (l2p_deg),
        .addr_b_i   (p2l_deg),
        .tan_a_o    (tan_l2p),
        .tan_b_o    (tan_p2l)
    );

    ////////////////////////////////////////////////////////////////////////////////
    wire logic [ORTT_ACC_W-1:0] x_mag;
    wire logic [ORTT_ACC_W-1:0] y_mag;
    wire logic [PROD_W-1:0]     y_scaled;
    wire logic [PROD_W-1:0]     x_l2p;
    wire logic [PROD_W-1:0]     x_p2l;
    wire logic                  go_portrait;
    wire logic                  go_landscape;
    wire logic                  next_portrait;
    ortt_orient_e               next_orient;

    assign x_mag = mag(sample_i.x);
    assign y_mag = mag(sample_i.y);

    // RULE_06 tangent ratio compare
    assign y_scaled = PROD_W'({y_mag, {ORTT_TAN_FRAC{1'b0}}});
    assign x_l2p    = PROD_W'(x_mag) * PROD_W'(tan_l2p);
    assign x_p2l    = PROD_W'(x_mag) * PROD_W'(tan_p2l);

    // RULE_04 direction dependent trip angle
    assign go_portrait  = y_scaled > x_l2p;
    assign go_landscape = y_scaled < x_p2l;

    // The class only flips across the band between the two trip angles, so noise near the
    // threshold cannot make the output chatter.
    assign next_portrait = is_portrait(orient_o) ? !go_landscape : go_portrait;

    // RULE_05 ideal orientation by sign
    always_comb begin
        next_orient = orient_o;
        case ({next_portrait, next_portrait ? sample_i.y[ORTT_ACC_W-1]
                                             : sample_i.x[ORTT_ACC_W-1]})
            2'b11: begin
                next_orient = ORTT_PORTRAIT_UP;
            end
            2'b10: begin
                next_orient = ORTT_PORTRAIT_DOWN;
            end
            2'b00: begin
                next_orient = ORTT_LANDSCAPE_RIGHT;
            end
            2'b01: begin
                next_orient = ORTT_LANDSCAPE_LEFT;
            end
            default: begin
                next_orient = orient_o;
            end
        endcase
    end

    // RULE_06 update once per sample
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            orient_o        <= ORTT_PORTRAIT_UP;
            orient_valid_o  <= 1'b0;
            orient_change_o <= 1'b0;
        end else begin
            orient_valid_o  <= sample_valid_i;
            orient_change_o <= sample_valid_i && (next_orient != orient_o);
            if (sample_valid_i) begin
                orient_o <= next_orient;
            end
        end
    end

endmodule

// [logic/ortt_pkg.sv]
// Package with constants and types for the orientation trip threshold block.
package ortt_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] ORTT_CFG_ADDR   = 8'h2C;
    localparam logic [7:0] ORTT_CFG_RESET  = 8'h84;
    localparam int         ORTT_THS_MSB    = 7;
    localparam int         ORTT_THS_LSB    = 3;
    localparam int         ORTT_HYS_MSB    = 2;
    localparam int         ORTT_HYS_LSB    = 0;
    localparam int         ORTT_ACC_W      = 12;
    localparam int         ORTT_ANG_W      = 7;
    localparam int         ORTT_TAN_W      = 16;
    localparam int         ORTT_TAN_FRAC   = 10;
    localparam logic [6:0] ORTT_ANGLE_MAX  = 7'h5A;

    // Threshold angles in tenths of a degree, indexed by threshold code.
    localparam logic [9:0] ORTT_THS_TENTHS [0:31] = '{
        10'h000, 10'h012, 10'h026, 10'h03B, 10'h051, 10'h069, 10'h082, 10'h09C,
        10'h0B8, 10'h0D6, 10'h0F4, 10'h114, 10'h136, 10'h158, 10'h17B, 10'h19E,
        10'h1C2, 10'h1E6, 10'h209, 10'h22C, 10'h24E, 10'h270, 10'h290, 10'h2AE,
        10'h2CC, 10'h2E8, 10'h302, 10'h31B, 10'h333, 10'h349, 10'h35E, 10'h372
    };

    // Hysteresis angles in whole degrees, indexed by hysteresis code.
    localparam logic [6:0] ORTT_HYS_DEG [0:7] = '{
        7'h00, 7'h04, 7'h07, 7'h0B, 7'h0E, 7'h11, 7'h15, 7'h18
    };

    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic signed [11:0] x;
        logic signed [11:0] y;
    } ortt_sample_s;

    typedef enum logic [3:0] {
        ORTT_PORTRAIT_UP      = 4'h1,
        ORTT_PORTRAIT_DOWN    = 4'h2,
        ORTT_LANDSCAPE_RIGHT  = 4'h4,
        ORTT_LANDSCAPE_LEFT   = 4'h8
    } ortt_orient_e;

    typedef struct packed {
        logic [6:0] l2p_deg;
        logic [6:0] p2l_deg;
    } ortt_trip_s;

endpackage

// [logic/ortt_tan_rom.sv]
// Dual-read tangent table, whole degrees 0 to 90, registered outputs.
`timescale 1ns/100ps
module ortt_tan_rom
    import ortt_pkg::*;
(
    input  wire logic                  core_clk_i,
    input  wire logic                  rst_b_i,
    input  wire logic [ORTT_ANG_W-1:0] addr_a_i,
    input  wire logic [ORTT_ANG_W-1:0] addr_b_i,
    output logic      [ORTT_TAN_W-1:0] tan_a_o,
    output logic      [ORTT_TAN_W-1:0] tan_b_o
);

    // Tangent scaled by 1024; 90 degrees saturates at full scale.
    localparam logic [15:0] TAN_TBL [0:90] = '{
        16'h0000, 16'h0012, 16'h0024, 16'h0036, 16'h0048, 16'h005A, 16'h006C, 16'h007E,
        16'h0090, 16'h00A2, 16'h00B5, 16'h00C7, 16'h00DA, 16'h00EC, 16'h00FF, 16'h0112,
        16'h0126, 16'h0139, 16'h014D, 16'h0161, 16'h0175, 16'h0189, 16'h019E, 16'h01B3,
        16'h01C8, 16'h01DD, 16'h01F3, 16'h020A, 16'h0220, 16'h0238, 16'h024F, 16'h0267,
        16'h0280, 16'h0299, 16'h02B3, 16'h02CD, 16'h02E8, 16'h0304, 16'h0320, 16'h033D,
        16'h035B, 16'h037A, 16'h039A, 16'h03BB, 16'h03DD, 16'h0400, 16'h0424, 16'h044A,
        16'h0471, 16'h049A, 16'h04C4, 16'h04F1, 16'h051F, 16'h054F, 16'h0581, 16'h05B6,
        16'h05EE, 16'h0629, 16'h0667, 16'h06A8, 16'h06EE, 16'h0737, 16'h0786, 16'h07DA,
        16'h0834, 16'h0894, 16'h08FC, 16'h096C, 16'h09E6, 16'h0A6C, 16'h0AFD, 16'h0B9E,
        16'h0C50, 16'h0D15, 16'h0DF3, 16'h0EEE, 16'h100B, 16'h1153, 16'h12D2, 16'h1494,
        16'h16AF, 16'h1941, 16'h1C76, 16'h2094, 16'h260F, 16'h2DB8, 16'h3934, 16'h4C53,
        16'h728C, 16'hE529, 16'hFFFF
    };

    wire logic [ORTT_ANG_W-1:0] safe_a;
    wire logic [ORTT_ANG_W-1:0] safe_b;

    // Addresses above 90 never occur upstream, but are clamped so the table is never overrun.
    assign safe_a = (addr_a_i > ORTT_ANGLE_MAX) ? ORTT_ANGLE_MAX : addr_a_i;
    assign safe_b = (addr_b_i > ORTT_ANGLE_MAX) ? ORTT_ANGLE_MAX : addr_b_i;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tan_a_o <= 16'h0000;
            tan_b_o <= 16'h0000;
        end else begin
            tan_a_o <= TAN_TBL[safe_a];
            tan_b_o <= TAN_TBL[safe_b];
        end
    end

endmodule

// [sim/ortt_core_sva.sv]
// Checker with concurrent properties on the orientation trip threshold ports.
`timescale 1ns/100ps
module ortt_core_sva
    import ortt_pkg::*;
(
    input wire logic         core_clk_i,
    input wire logic         rst_b_i,
    input wire logic [7:0]   reg_addr_i,
    input wire logic         reg_wr_i,
    input wire logic [7:0]   reg_wdata_i,
    input wire logic         reg_rd_i,
    input wire logic [7:0]   reg_rdata_o,
    input wire logic         sample_valid_i,
    input wire ortt_sample_s sample_i,
    input wire ortt_orient_e orient_o,
    input wire logic         orient_valid_o,
    input wire logic         orient_change_o,
    input wire ortt_trip_s   trip_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    ////////////////////////////////////////////////////////////////////////////////
    a_unmapped_reads_zero: assert property (
        reg_rd_i && reg_addr_i != 8'h2C |=> reg_rdata_o == 8'h00) else $error("bad unmapped read");
    a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved");
    a_trip_ordered: assert property (trip_o.l2p_deg >= trip_o.p2l_deg)
        else $error("trip angles inverted");
    a_sample_answered: assert property (
        sample_valid_i |=> orient_valid_o ##1 (!orient_valid_o || $past(sample_valid_i)))
        else $error("no answer");
    a_orient_holds: assert property (!orient_valid_o |-> $stable(orient_o))
        else $error("orientation moved without sample");
    a_orient_onehot: assert property ($onehot(orient_o))
        else $error("orientation not one-hot");
    a_change_flagged: assert property (
        orient_change_o |-> orient_valid_o && orient_o != $past(orient_o))
        else $error("change flag without change");
    a_change_raised: assert property (
        orient_valid_o && orient_o != $past(orient_o) |-> orient_change_o)
        else $error("change not flagged");
    a_landscape_sign: assert property (orient_valid_o && orient_o == ORTT_LANDSCAPE_RIGHT
        |-> !$past(sample_i.x[11])) else $error("right with negative x");
    a_portrait_sign: assert property (orient_valid_o && orient_o == ORTT_PORTRAIT_UP
        |-> $past(sample_i.y[11])) else $error("up with non-negative y");
    c_write: cover property (reg_wr_i && reg_addr_i == 8'h2C);
    c_change: cover property (orient_change_o);
    c_left: cover property (orient_valid_o && orient_o == ORTT_LANDSCAPE_LEFT);
endmodule
bind ortt_core ortt_core_sva u_sva (.core_clk_i, .rst_b_i, .reg_addr_i, .reg_wr_i,
    .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .sample_valid_i, .sample_i, .orient_o,
    .orient_valid_o, .orient_change_o, .trip_o);

// [sim/ortt_core_test.sv]
// Self-checking bench for the orientation trip threshold core.
`timescale 1ns/100ps
module ortt_core_test;
    import ortt_pkg::*;
    logic         core_clk_i = 1'b0;
    logic         rst_b_i = 1'b0;
    logic [7:0]   reg_addr_i = 8'h00;
    logic         reg_wr_i = 1'b0;
    logic [7:0]   reg_wdata_i = 8'h00;
    logic         reg_rd_i = 1'b0;
    logic [7:0]   reg_rdata_o;
    logic         sample_valid_i = 1'b0;
    ortt_sample_s sample_i = '0;
    ortt_orient_e orient_o;
    logic         orient_valid_o;
    logic         orient_change_o;
    ortt_trip_s   trip_o;
    int           mismatches = 0;
    int           compares = 0;
    int           ang [0:31] = '{0, 18, 38, 59, 81, 105, 130, 156, 184, 214, 244, 276, 310,
        344, 379, 414, 450, 486, 521, 556, 590, 624, 656, 686, 716, 744, 770, 795, 819, 841,
        862, 882};
    int           hys [0:7] = '{0, 4, 7, 11, 14, 17, 21, 24};
    always #20 core_clk_i = ~core_clk_i;
    ortt_core uut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .sample_valid_i(sample_valid_i), .sample_i(sample_i),
        .orient_o(orient_o), .orient_valid_o(orient_valid_o),
        .orient_change_o(orient_change_o), .trip_o(trip_o));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input bit ok, input string msg);
        compares++;
        if (!ok) begin
            mismatches++;
            $display("unexpected %0t %s", $time, msg);
        end
    endtask
    task automatic finish_test;
        if (mismatches == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(reg_rdata_o === e, "read data");
    endtask
    task automatic trip(input int l, input int p);
        chk(trip_o.l2p_deg === 7'(l) && trip_o.p2l_deg === 7'(p), "trip angles");
    endtask
    task automatic smp(input int x, input int y, input ortt_orient_e e, input logic c);
        @(posedge core_clk_i);
        sample_i.x <= 12'(x);
        sample_i.y <= 12'(y);
        sample_valid_i <= 1'b1;
        @(posedge core_clk_i);
        sample_valid_i <= 1'b0;
        #1;
        chk(orient_valid_o === 1'b1 && orient_o === e && orient_change_o === c, "orient");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge core_clk_i);
        mismatches++;
        finish_test;
    end
    initial begin
        repeat (5) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        #1;
        trip(59, 31);
        rd(8'h2C, 8'h84);
        wr(8'h2D, 8'h5A);
        rd(8'h2C, 8'h84);
        rd(8'h2D, 8'h00);
        for (int h = 0; h < 8; h++) begin
            wr(8'h2C, {5'h10, 3'(h)});
            trip(45 + hys[h], 45 - hys[h]);
            rd(8'h2C, {5'h10, 3'(h)});
        end
        for (int t = 0; t < 32; t++) begin
            wr(8'h2C, {5'(t), 3'h0});
            trip((ang[t] + 5) / 10, (ang[t] + 5) / 10);
        end
        // Large hysteresis on extreme thresholds must clamp at 90 and at 0 degrees.
        wr(8'h2C, {5'h1F, 3'h7});
        trip(90, 64);
        rd(8'h2C, {5'h1F, 3'h7});
        wr(8'h2C, {5'h02, 3'h7});
        trip(28, 0);
        wr(8'h2C, 8'h84);
        // Angles between the two trip points show that the class is kept.
        smp(1024, 0, ORTT_LANDSCAPE_RIGHT, 1'b1);
        smp(-1024, 0, ORTT_LANDSCAPE_LEFT, 1'b1);
        smp(1024, 1024, ORTT_LANDSCAPE_RIGHT, 1'b1);
        smp(512, 1024, ORTT_PORTRAIT_DOWN, 1'b1);
        smp(1024, 1024, ORTT_PORTRAIT_DOWN, 1'b0);
        smp(0, -1024, ORTT_PORTRAIT_UP, 1'b1);
        smp(1024, 512, ORTT_LANDSCAPE_RIGHT, 1'b1);
        // A reset in mid-run must restore the default threshold over a written one.
        wr(8'h2C, 8'h3A);
        @(posedge core_clk_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        #1;
        chk(orient_o === ORTT_PORTRAIT_UP && orient_valid_o === 1'b0, "reset orient");
        trip(59, 31);
        rd(8'h2C, 8'h84);
        finish_test;
    end
endmodule
